//--- design/eas_pkg.sv
package eas_pkg;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  // signature space addresses
  localparam logic [7:0] SIG_ADDR_MAKER = 8'h30;
  localparam logic [7:0] SIG_ADDR_FAMILY = 8'h31;
  localparam logic [7:0] SIG_ADDR_PRODUCT = 8'h60;
  localparam logic [7:0] SIG_ADDR_REVISION = 8'h61;
  // value returned for signature addresses that hold nothing
  localparam logic [7:0] SIG_EMPTY = 8'h00;
  // control line codes seen on the mode pins
  localparam logic [2:0] CTRL_CODE_VERIFY = 3'h1;
  localparam logic [2:0] CTRL_CODE_SIGNATURE = 3'h2;
  // access time limits, in oscillator periods
  localparam int ACCESS_MAX_OSC = 48;
  localparam int FLOAT_MAX_OSC = 48;
  // oscillator and system clock periods in picoseconds
  localparam int OSC_PERIOD_PS = 4000;
  localparam int CLK_PERIOD_PS = 4000;
  // longest times round down to whole cycles, at least one
  localparam int ACCESS_MAX_CYC_RAW = (ACCESS_MAX_OSC * OSC_PERIOD_PS) / CLK_PERIOD_PS;
  localparam int ACCESS_MAX_CYC = (ACCESS_MAX_CYC_RAW < 1) ? 1 : ACCESS_MAX_CYC_RAW;
  localparam int FLOAT_MAX_CYC_RAW = (FLOAT_MAX_OSC * OSC_PERIOD_PS) / CLK_PERIOD_PS;
  localparam int FLOAT_MAX_CYC = (FLOAT_MAX_CYC_RAW < 1) ? 1 : FLOAT_MAX_CYC_RAW;
  // number of ports on the device
  localparam int NUM_PORTS = 4;
  localparam logic [NUM_PORTS-1:0] PORTS_NONE = 4'h0;
  // weak pull pattern in emulation: port 0 floats, ports 1 to 3 pulled
  localparam logic [NUM_PORTS-1:0] EMU_WEAK_PATTERN = 4'he;
  // operating states of the test access logic
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_NORMAL = 2'b01,
    ST_EMULATE = 2'b10
  } eas_state_t;
endpackage

//--- design/eas_test_access.sv
`timescale 1ns/100ps
// How it works
// (R1) tester pulls strobe low during reset, store-strobe high
// (R2) tester keeps strobe low through reset release
// (R3) emulation: weak pulls, port 0 floats, oscillator on
// (R4) emulation: device releases all driven pins
// (R5) emulation lasts until next ordinary reset
// (R6) four read-only signature bytes at fixed addresses
// (R7) tester reads signature like verify, special code
// (R8) maker, family, product, revision bytes returned
// (R9) data valid within 48 periods of address
// (R10) data valid within 48 periods of read enable
// (R11) data floats within 48 periods of read end
// (R12) entry decided on synchronised reset release edge
module eas_test_access
#(
  parameter logic [7:0] MAKER_ID = 8'ha1,  // arbitrary value
  parameter logic [7:0] FAMILY_ID = 8'ha2,  // arbitrary value
  parameter logic [7:0] PRODUCT_ID = 8'ha3,  // arbitrary value
  parameter logic [7:0] REVISION_ID = 8'ha4  // arbitrary value
)
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic chip_rst_pin,
  input wire logic addr_latch_strobe_pin,
  input wire logic prog_store_strobe_n,
  input wire logic read_en_n,
  input wire logic [2:0] ctrl_code_pin,
  input wire logic [7:0] addr_pin,
  input wire logic [7:0] code_byte,
  input wire logic [eas_pkg::NUM_PORTS-1:0] core_port_oe,
  input wire logic core_strobe_oe,
  input wire logic core_store_oe,
  output logic emulation_mode,
  output logic [7:0] code_addr,
  output logic [eas_pkg::NUM_PORTS-1:0] port_oe,
  output logic [eas_pkg::NUM_PORTS-1:0] port_weak_pu,
  output logic strobe_oe,
  output logic strobe_weak_pu,
  output logic store_oe,
  output logic store_weak_pu,
  output logic oscillator_pins_active,
  output logic [7:0] p0_data_out,
  output logic p0_data_oe
);
  import eas_pkg::*;

  localparam int ACC_LIM = ACCESS_MAX_CYC;  // data valid bound
  localparam int FLT_LIM = FLOAT_MAX_CYC;  // float bound

  // signature lookup, read-only contents
  function automatic logic [7:0] sig_lookup(input logic [7:0] a);
    logic [7:0] v;
    v = SIG_EMPTY;
    case (a)
      SIG_ADDR_MAKER: v = MAKER_ID;
      SIG_ADDR_FAMILY: v = FAMILY_ID;
      SIG_ADDR_PRODUCT: v = PRODUCT_ID;
      SIG_ADDR_REVISION: v = REVISION_ID;
      default: v = SIG_EMPTY;
    endcase
    return v;
  endfunction

  // pin synchronisers: bundle of all pin inputs
  localparam int SW = 15;
  logic [SW-1:0] pin_raw;  // pins as they arrive
  logic [SW-1:0] sync_q [SYNC_STAGES];  // synchroniser stages
  logic [SW-1:0] pin_s;  // synchronised pins
  assign pin_raw = {chip_rst_pin, addr_latch_strobe_pin, prog_store_strobe_n, read_en_n, ctrl_code_pin, addr_pin};

  // two flops per pin, first read only by second
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < SYNC_STAGES; i++)
        sync_q[i] <= '0;
    end
    else
    begin
      sync_q[0] <= pin_raw;
      for (int i = 1; i < SYNC_STAGES; i++)
        sync_q[i] <= sync_q[i-1];
    end
  end
  assign pin_s = sync_q[SYNC_STAGES-1];

  logic rst_s;  // chip reset level
  logic strobe_s;  // address latch strobe level
  logic store_n_s;  // program store strobe level
  logic rd_n_s;  // read enable, active low
  logic [2:0] code_s;  // control line code
  logic [7:0] addr_s;  // verify address
  assign rst_s = pin_s[14];
  assign strobe_s = pin_s[13];
  assign store_n_s = pin_s[12];
  assign rd_n_s = pin_s[11];
  assign code_s = pin_s[10:8];
  assign addr_s = pin_s[7:0];

  // mode state group
  eas_state_t state;  // current mode
  eas_state_t next_state;  // next mode

  // mode decision on reset release
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
      begin
        // sample strobes on the releasing edge
        if (!rst_s)
          next_state = (!strobe_s && store_n_s) ? ST_EMULATE : ST_NORMAL;  // R12 R1 R2
      end
      ST_NORMAL:
      begin
        if (rst_s)
          next_state = ST_RESET;
      end
      ST_EMULATE:
      begin
        // only a fresh reset leaves emulation
        if (rst_s)
          next_state = ST_RESET;  // R5
      end
      default: next_state = ST_RESET;
    endcase
  end

  // mode register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  assign emulation_mode = (state == ST_EMULATE);

  // pin release and weak pulls in emulation
  always_comb
  begin
    if (emulation_mode)
    begin
      port_oe = PORTS_NONE;  // R4
      port_weak_pu = EMU_WEAK_PATTERN;  // R3
      strobe_oe = 1'b0;  // R4
      store_oe = 1'b0;
      strobe_weak_pu = 1'b1;  // R3
      store_weak_pu = 1'b1;
    end
    else
    begin
      port_oe = core_port_oe;
      port_weak_pu = PORTS_NONE;
      strobe_oe = core_strobe_oe;
      store_oe = core_store_oe;
      strobe_weak_pu = 1'b0;
      store_weak_pu = 1'b0;
    end
  end
  assign oscillator_pins_active = 1'b1;  // R3

  // read path state group
  logic read_req;  // verify or signature read active
  logic sig_sel;  // signature code selected
  logic [7:0] next_data;  // next port 0 byte
  logic next_oe;  // next port 0 drive
  logic [7:0] addr_q;  // registered code memory address

  // select data source for the read
  always_comb
  begin
    sig_sel = (code_s == CTRL_CODE_SIGNATURE);
    read_req = !rd_n_s && !emulation_mode && (sig_sel || code_s == CTRL_CODE_VERIFY);
    next_oe = read_req;  // R10 R11
    if (!read_req)
      next_data = p0_data_out;
    else if (sig_sel)
      next_data = sig_lookup(addr_s);  // R6 R8
    else
      next_data = code_byte;  // R9
  end

  // read path registers
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p0_data_out <= 8'h00;
      p0_data_oe <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      p0_data_out <= next_data;
      p0_data_oe <= next_oe;
      addr_q <= addr_s;
    end
  end
  assign code_addr = addr_q;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  chk_entry_decision: assert property ((state == ST_RESET && !rst_s && !strobe_s && store_n_s) |=> emulation_mode) // R12
    else $error("emulation not entered on reset release");
  chk_normal_entry: assert property ((state == ST_RESET && !rst_s && strobe_s) |=> state == ST_NORMAL) // R12
    else $error("emulation entered with strobe high");
  chk_emu_hold: assert property ((emulation_mode && !rst_s) |=> emulation_mode) // R5
    else $error("emulation left without reset");
  chk_emu_exit: assert property ((emulation_mode && rst_s) |=> !emulation_mode ##1 !emulation_mode) // R5
    else $error("emulation kept through reset");
  chk_pin_pulls: assert property (emulation_mode |-> (port_weak_pu == EMU_WEAK_PATTERN && strobe_weak_pu && store_weak_pu
    && oscillator_pins_active)) // R3
    else $error("wrong pin state in emulation");
  chk_pin_release: assert property (emulation_mode |-> (port_oe == PORTS_NONE && !strobe_oe && !store_oe && !p0_data_oe)) // R4
    else $error("pin driven in emulation");
  chk_sig_bytes: assert property ((read_req && sig_sel && addr_s == SIG_ADDR_PRODUCT) |=> p0_data_out == PRODUCT_ID) // R8
    else $error("wrong product signature byte");
  chk_sig_maker: assert property ((read_req && sig_sel && addr_s == SIG_ADDR_MAKER) |=> p0_data_out == MAKER_ID) // R6
    else $error("wrong maker signature byte");
  chk_data_valid: assert property ((!emulation_mode && !rst_s && $fell(read_en_n) && ctrl_code_pin == CTRL_CODE_VERIFY)
    ##1 (!read_en_n && ctrl_code_pin == CTRL_CODE_VERIFY && !emulation_mode)[*3] |-> ##[0:ACC_LIM] p0_data_oe) // R10
    else $error("data not valid in time");
  chk_addr_valid: assert property ((read_req && !sig_sel && $stable(addr_s)) |=> p0_data_out == $past(code_byte)) // R9
    else $error("verify data not from code memory");
  chk_data_float: assert property (($rose(read_en_n) ##1 read_en_n[*3]) |-> ##[0:FLT_LIM] !p0_data_oe) // R11
    else $error("data not floated in time");

  cov_emu_entry: cover property (state == ST_RESET ##1 emulation_mode);
  cov_sig_read: cover property (read_req && sig_sel ##1 p0_data_oe);
  cov_verify_read: cover property (read_req && !sig_sel ##1 p0_data_oe);
  cov_emu_leave: cover property (emulation_mode ##1 state == ST_RESET);
endmodule

//--- testbench/eas_tester_model.sv
`timescale 1ns/100ps
// programmer or emulator that drives the test pins
module eas_tester_model
(
  input wire logic sys_clk,
  output logic chip_rst_pin,
  output logic addr_latch_strobe_pin,
  output logic prog_store_strobe_n,
  output logic read_en_n,
  output logic [2:0] ctrl_code_pin,
  output logic [7:0] addr_pin
);
  // pins idle, chip held in reset
  initial
  begin
    chip_rst_pin = 1'b1;
    addr_latch_strobe_pin = 1'b1;
    prog_store_strobe_n = 1'b1;
    read_en_n = 1'b1;
    ctrl_code_pin = 3'h0;
    addr_pin = 8'h00;
  end
  // reset pulse with a chosen strobe level, held through release
  task automatic pulse_reset(input logic strobe);
    @(negedge sys_clk);
    chip_rst_pin = 1'b1;
    addr_latch_strobe_pin = strobe;
    prog_store_strobe_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chip_rst_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    addr_latch_strobe_pin = 1'b1;
  endtask
  // read as a verify cycle, code picks verify or signature
  task automatic start_read(input logic [2:0] code, input logic [7:0] addr);
    @(negedge sys_clk);
    ctrl_code_pin = code;
    addr_pin = addr;
    read_en_n = 1'b0;
  endtask
  // end read; address no longer meaningful, so invert it
  task automatic end_read();
    @(negedge sys_clk);
    read_en_n = 1'b1;
    addr_pin = ~addr_pin;
  endtask
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
  import eas_pkg::*;
  localparam logic [7:0] ID_M = 8'h1b; // arbitrary value
  localparam logic [7:0] ID_F = 8'h2c; // arbitrary value
  localparam logic [7:0] ID_P = 8'h3d; // arbitrary value
  localparam logic [7:0] ID_R = 8'h4e; // arbitrary value
  logic sys_clk = 1'b0, arst_n = 1'b0, core_strobe_oe = 1'b1, core_store_oe = 1'b1;
  logic chip_rst_pin, addr_latch_strobe_pin, prog_store_strobe_n, read_en_n;
  logic [2:0] ctrl_code_pin;
  logic [7:0] addr_pin, code_byte, code_addr, p0_data_out;
  logic [3:0] core_port_oe = 4'h5, port_oe, port_weak_pu;
  logic emulation_mode, strobe_oe, strobe_weak_pu, store_oe, store_weak_pu, oscillator_pins_active, p0_data_oe;
  int mismatches = 0, comparisons = 0;
  // code memory stand-in: nibble swap of the address
  assign code_byte = {code_addr[3:0], code_addr[7:4]};
  eas_tester_model tm (.sys_clk(sys_clk), .chip_rst_pin(chip_rst_pin), .addr_latch_strobe_pin(addr_latch_strobe_pin),
    .prog_store_strobe_n(prog_store_strobe_n), .read_en_n(read_en_n), .ctrl_code_pin(ctrl_code_pin), .addr_pin(addr_pin));
  eas_test_access #(.MAKER_ID(ID_M), .FAMILY_ID(ID_F), .PRODUCT_ID(ID_P), .REVISION_ID(ID_R)) DUT (.sys_clk(sys_clk),
    .arst_n(arst_n), .chip_rst_pin(chip_rst_pin), .addr_latch_strobe_pin(addr_latch_strobe_pin),
    .prog_store_strobe_n(prog_store_strobe_n), .read_en_n(read_en_n), .ctrl_code_pin(ctrl_code_pin),
    .addr_pin(addr_pin), .code_byte(code_byte), .core_port_oe(core_port_oe), .core_strobe_oe(core_strobe_oe),
    .core_store_oe(core_store_oe), .emulation_mode(emulation_mode), .code_addr(code_addr), .port_oe(port_oe),
    .port_weak_pu(port_weak_pu), .strobe_oe(strobe_oe), .strobe_weak_pu(strobe_weak_pu), .store_oe(store_oe),
    .store_weak_pu(store_weak_pu), .oscillator_pins_active(oscillator_pins_active), .p0_data_out(p0_data_out),
    .p0_data_oe(p0_data_oe));
  // 250 MHz clock
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  // verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // wait for port 0 drive to reach a level within the access limit
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (p0_data_oe !== lvl && n < ACCESS_MAX_CYC)
    begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("p0_data_oe", lvl, p0_data_oe)
  endtask
  // strobe high at release gives normal mode with core drives
  task automatic t_normal();
    tm.pulse_reset(1'b1);
    `CHK("emulation_mode", 1'b0, emulation_mode)
    `CHK("port_oe", 4'h5, port_oe)
    `CHK("strobe_oe", 1'b1, strobe_oe)
    `CHK("strobe_weak_pu", 1'b0, strobe_weak_pu)
  endtask
  // all signature bytes plus an empty address, back to back
  task automatic t_signature();
    logic [7:0] a[5] = '{SIG_ADDR_MAKER, SIG_ADDR_FAMILY, SIG_ADDR_PRODUCT, SIG_ADDR_REVISION, 8'h45};
    logic [7:0] e[5] = '{ID_M, ID_F, ID_P, ID_R, SIG_EMPTY};
    for (int i = 0; i < 5; i++)
    begin
      tm.start_read(CTRL_CODE_SIGNATURE, a[i]);
      wait_oe(1'b1);
      `CHK("signature", e[i], p0_data_out)
      tm.end_read();
      wait_oe(1'b0);
    end
  endtask
  // verify read returns the code byte of the address
  task automatic t_verify();
    tm.start_read(CTRL_CODE_VERIFY, 8'h3c);
    wait_oe(1'b1);
    repeat (3) @(negedge sys_clk);
    `CHK("verify", 8'hc3, p0_data_out)
    tm.end_read();
    wait_oe(1'b0);
  endtask
  // emulation entry, pin states, refused read, exit by reset
  task automatic t_emulate();
    tm.pulse_reset(1'b0);
    `CHK("emulation_mode", 1'b1, emulation_mode)
    `CHK("port_oe", PORTS_NONE, port_oe)
    `CHK("oe_strobes", 2'b00, {strobe_oe, store_oe})
    `CHK("port_weak_pu", EMU_WEAK_PATTERN, port_weak_pu)
    `CHK("weak_strobes", 2'b11, {strobe_weak_pu, store_weak_pu})
    `CHK("osc_active", 1'b1, oscillator_pins_active)
    tm.start_read(CTRL_CODE_SIGNATURE, SIG_ADDR_MAKER);
    repeat (6) @(negedge sys_clk);
    `CHK("emu_read_oe", 1'b0, p0_data_oe)
    `CHK("still_emulating", 1'b1, emulation_mode)
    tm.end_read();
    tm.pulse_reset(1'b1);
    `CHK("emulation_mode", 1'b0, emulation_mode)
    `CHK("port_oe", 4'h5, port_oe)
  endtask
  // reset for 10 cycles, then the scenarios
  initial
  begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_normal();
    t_signature();
    t_verify();
    t_emulate();
    t_signature();
    test_done();
  end
endmodule
